// ===== logic/dtil_pkg.sv
package dtil_pkg;
   // Defaults for the core parameters
   localparam int NCH_DEF = 8;
   localparam int SIZE_W_DEF = 16;

   // Byte addresses on the register bus
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STAT = 8'h04;
   localparam logic [7:0] ADR_VEC = 8'h08;
   localparam logic [7:0] ADR_CHEN = 8'h0C;
   localparam logic [7:0] ADR_SIZE0 = 8'h20;

   // Field positions
   localparam int CTRL_NMI_BIT = 0;
   localparam int CTRL_IE_LSB = 8;
   localparam int CHEN_MODE_LSB = 8;
   localparam int STAT_BUSY_BIT = 8;
   localparam int STAT_CHAN_LSB = 9;

   // Reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CHEN_RST = 32'h0000_0000;
   localparam logic [31:0] SIZE_RST = 32'h0000_0000;

   // Timing: oscillator start-up bounds the wake wait
   localparam int CLK_PERIOD_NS = 50;
   localparam int OSC_START_NS = 5000;
   localparam int OSC_START_CYC = (OSC_START_NS / CLK_PERIOD_NS < 1) ? 1
                                  : OSC_START_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_SYNC = 3'h1,
      S_WAKE = 3'h3,
      S_MOVE_A = 3'h2,
      S_MOVE_B = 3'h6,
      S_WAIT = 3'h7
   } dtil_state_t;

   typedef enum logic [2:0] {
      SLP_ACTIVE = 3'h0,
      SLP_ZERO = 3'h1,
      SLP_ONE = 3'h2,
      SLP_THREE = 3'h3,
      SLP_FOUR = 3'h4
   } dtil_sleep_t;

   typedef struct packed {
      dtil_sleep_t sleep;
      logic src_crystal;
   } dtil_power_t;

   typedef struct packed {
      logic busy;
      logic [2:0] chan;
      logic rd;
      logic wr;
      logic done;
   } dtil_xfer_t;
endpackage : dtil_pkg

// ===== logic/dtil_dma_core.sv
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
module dtil_dma_core
   import dtil_pkg::*;
#(
   parameter int N_CH = NCH_DEF,
   parameter int SZW = SIZE_W_DEF
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Triggers and system state
   input wire logic [N_CH-1:0] trig_i,
   input wire dtil_power_t power_i,
   input wire logic global_irq_enable_i,
   input wire logic nmi_i,
   // Transfer and system control
   output dtil_xfer_t xfer_o,
   output logic cpu_halt_o,
   output logic sys_irq_hold_o,
   output logic mclk_restart_o,
   output logic irq_o
);
   localparam int WCW = $clog2(OSC_START_CYC + 1);
   localparam logic [WCW-1:0] WAKE_LOAD = WCW'(OSC_START_CYC - 1);
   localparam int WAKE_MAX = OSC_START_CYC + 1;
   if (N_CH < 1 || N_CH > 8 || SZW < 2 || SZW > 32)
   begin : g_bad_param
      $error("dtil_dma_core: N_CH must be 1..8 and SZW 2..32");
   end
   dtil_state_t state, next_state;
   logic [2:0] cur, next_cur;
   logic [WCW-1:0] wake_cnt;
   logic stopped;
   logic nmi_abort_enable;
   logic [N_CH-1:0] channel_irq_enable;
   logic [N_CH-1:0] ch_en;
   logic [N_CH-1:0] ch_block;
   logic [N_CH-1:0] pend;
   logic [N_CH-1:0] trig_q;
   logic [N_CH-1:0] channel_done_flag;
   logic [SZW-1:0] transfer_size_counter [N_CH];

   // Bus decode
   wire wb_req = wb_cyc_i && wb_stb_i;
   wire wb_hit = wb_req && wb_ack_o;
   wire wb_wr = wb_hit && wb_we_i;
   wire sel_ctrl = wb_adr_i[7:2] == ADR_CTRL[7:2];
   wire sel_stat = wb_adr_i[7:2] == ADR_STAT[7:2];
   wire sel_vec = wb_adr_i[7:2] == ADR_VEC[7:2];
   wire sel_chen = wb_adr_i[7:2] == ADR_CHEN[7:2];
   wire sel_size = wb_adr_i[7:5] == ADR_SIZE0[7:5];
   wire [2:0] size_idx = wb_adr_i[4:2];
   wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // Interrupt vector: lowest enabled pending channel wins
   wire [N_CH-1:0] masked = channel_done_flag & channel_irq_enable;
   wire [N_CH-1:0] top_oh = masked & N_CH'(~masked + 1'b1);
   wire vec_access = wb_hit && sel_vec;
   wire [N_CH-1:0] vec_clr = vec_access ? top_oh : '0;
   wire [N_CH-1:0] stat_clr = (wb_wr && sel_stat) ? N_CH'(wb_dat_i & wmask) : '0;
   logic [4:0] irq_vector_word;

   always_comb
   begin
      irq_vector_word = 5'h00;
      for (int i = N_CH - 1; i >= 0; i--)
      begin
         if (masked[i])
         begin
            irq_vector_word = 5'((i + 1) * 2);
         end
      end
   end

   assign irq_o = global_irq_enable_i && (|masked);

   // Channel arbitration, fixed order
   wire [N_CH-1:0] size_nz;
   wire [N_CH-1:0] eligible = pend & ch_en & size_nz;
   wire [N_CH-1:0] grant_oh = eligible & N_CH'(~eligible + 1'b1);
   logic [2:0] grant_idx;

   always_comb
   begin
      grant_idx = 3'h0;
      for (int i = N_CH - 1; i >= 0; i--)
      begin
         if (grant_oh[i])
         begin
            grant_idx = 3'(i);
         end
      end
   end

   // Clock stopped in deep sleep: internal source in three/four, crystal in four
   wire clk_off = power_i.sleep == SLP_FOUR
                  || (power_i.sleep == SLP_THREE && !power_i.src_crystal);
   wire busy = state != S_IDLE;
   wire abort = busy && nmi_i && nmi_abort_enable;
   wire start = state == S_IDLE && (|eligible);
   wire [SZW-1:0] cur_size = transfer_size_counter[cur];
   wire last = cur_size == SZW'(1);
   wire step = state == S_WAIT && !abort;
   wire [N_CH-1:0] cur_oh = N_CH'(1) << cur;
   wire [N_CH-1:0] step_oh = step ? cur_oh : '0;
   wire [N_CH-1:0] done_oh = (step && last) ? cur_oh : '0;

   always_comb
   begin
      next_state = state;
      next_cur = cur;
      case (state)
         S_IDLE:
         begin
            if (start)
            begin
               next_state = S_SYNC;
               next_cur = grant_idx;
            end
         end
         S_SYNC:
         begin
            next_state = (power_i.sleep == SLP_ACTIVE) ? S_MOVE_A : S_WAKE;
         end
         S_WAKE:
         begin
            if (!stopped || wake_cnt == '0)
            begin
               next_state = S_MOVE_A;
            end
         end
         S_MOVE_A:
         begin
            next_state = S_MOVE_B;
         end
         S_MOVE_B:
         begin
            next_state = S_WAIT;
         end
         S_WAIT:
         begin
            // Block mode keeps moving without a new synchronisation
            next_state = (ch_block[cur] && !last) ? S_MOVE_A : S_IDLE;
         end
         default:
         begin
            next_state = S_IDLE;
         end
      endcase
      if (abort)
      begin
         next_state = S_IDLE;
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= S_IDLE;
         cur <= 3'h0;
         stopped <= 1'b0;
         wake_cnt <= '0;
      end
      else
      begin
         state <= next_state;
         cur <= next_cur;
         if (state == S_SYNC)
         begin
            stopped <= clk_off;
            wake_cnt <= WAKE_LOAD;
         end
         else if (state == S_WAKE && wake_cnt != '0)
         begin
            wake_cnt <= wake_cnt - 1'b1;
         end
      end
   end

   // Registered transfer strobes
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         xfer_o <= '0;
      end
      else
      begin
         xfer_o.busy <= next_state != S_IDLE;
         xfer_o.chan <= next_cur;
         xfer_o.rd <= next_state == S_MOVE_A;
         xfer_o.wr <= next_state == S_MOVE_B;
         xfer_o.done <= step && last;
      end
   end

   // Processor stays halted and maskable interrupts wait while busy
   assign cpu_halt_o = busy;
   assign sys_irq_hold_o = busy;
   // Held only for the transfer, so the clock stops again afterwards
   assign mclk_restart_o = busy && state != S_SYNC && stopped;

   // Per-channel state
   genvar g;
      for (g = 0; g < N_CH; g++)
      begin : g_ch
         wire size_we = wb_wr && sel_size && size_idx == 3'(g);
         assign size_nz[g] = transfer_size_counter[g] != '0;
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               channel_done_flag[g] <= 1'b0;
               transfer_size_counter[g] <= SZW'(SIZE_RST);
               pend[g] <= 1'b0;
               trig_q[g] <= 1'b0;
               ch_en[g] <= CHEN_RST[g];
            end
            else
            begin
               trig_q[g] <= trig_i[g];
               // Set wins over any clear in the same cycle
               channel_done_flag[g] <= done_oh[g]
                  || (channel_done_flag[g] && !vec_clr[g] && !stat_clr[g]);
               if (trig_i[g] && !trig_q[g] && ch_en[g])
               begin
                  pend[g] <= 1'b1;
               end
               else if ((start && grant_oh[g]) || !ch_en[g])
               begin
                  pend[g] <= 1'b0;
               end
               if (size_we)
               begin
                  transfer_size_counter[g] <= SZW'(wb_dat_i & wmask);
               end
               else if (step_oh[g])
               begin
                  transfer_size_counter[g] <= transfer_size_counter[g] - 1'b1;
               end
               if (wb_wr && sel_chen && wb_sel_i[0])
               begin
                  ch_en[g] <= wb_dat_i[g];
               end
               else if (done_oh[g])
               begin
                  ch_en[g] <= 1'b0;
               end
            end
         end
      end
   // Control word and mode bits
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         nmi_abort_enable <= CTRL_RST[CTRL_NMI_BIT];
         channel_irq_enable <= CTRL_RST[CTRL_IE_LSB +: N_CH];
         ch_block <= CHEN_RST[CHEN_MODE_LSB +: N_CH];
      end
      else if (wb_wr)
      begin
         if (sel_ctrl && wb_sel_i[0])
         begin
            nmi_abort_enable <= wb_dat_i[CTRL_NMI_BIT];
         end
         if (sel_ctrl && wb_sel_i[1])
         begin
            channel_irq_enable <= wb_dat_i[CTRL_IE_LSB +: N_CH];
         end
         if (sel_chen && wb_sel_i[1])
         begin
            ch_block <= wb_dat_i[CHEN_MODE_LSB +: N_CH];
         end
      end
   end

   // Read mux; unmapped addresses read zero
   logic [31:0] rdata;
   always_comb
   begin
      rdata = 32'h0000_0000;
      if (sel_ctrl)
      begin
         rdata[CTRL_NMI_BIT] = nmi_abort_enable;
         rdata[CTRL_IE_LSB +: N_CH] = channel_irq_enable;
      end
      else if (sel_stat)
      begin
         rdata[N_CH-1:0] = channel_done_flag;
         rdata[STAT_BUSY_BIT] = busy;
         rdata[STAT_CHAN_LSB +: 3] = cur;
      end
      else if (sel_vec)
      begin
         rdata[4:0] = irq_vector_word;
      end
      else if (sel_chen)
      begin
         rdata[N_CH-1:0] = ch_en;
         rdata[CHEN_MODE_LSB +: N_CH] = ch_block;
      end
      else if (sel_size && {1'b0, size_idx} < 4'(N_CH))
      begin
         rdata[SZW-1:0] = transfer_size_counter[size_idx];
      end
   end
   // One wait state: data is captured with ack, side effects land on the ack edge
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= wb_req && !wb_ack_o;
         if (wb_req && !wb_ack_o)
         begin
            wb_dat_o <= rdata;
         end
      end
   end
   sequence seq_move;
      state == S_MOVE_A ##1 state == S_MOVE_B ##1 state == S_WAIT;
   endsequence
   AST_SYNC_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(state) == S_IDLE && state != S_IDLE |-> state == S_SYNC)
      else $error("transfer started without synchronisation");
   AST_MOVE_TWO: assert property (@(posedge clk_i) disable iff (rst_i || abort)
      state == S_MOVE_A |-> ##1 state == S_MOVE_B ##1 state == S_WAIT)
      else $error("word move did not take two cycles plus wait");
   AST_ACTIVE_MAX4: assert property (@(posedge clk_i) disable iff (rst_i || abort)
      state == S_SYNC && power_i.sleep == SLP_ACTIVE |-> ##1 seq_move)
      else $error("active transfer exceeded four cycles");
   AST_SLEEP_MAX5: assert property (@(posedge clk_i) disable iff (rst_i || abort)
      state == S_SYNC && power_i.sleep != SLP_ACTIVE && !clk_off
      |-> ##1 state == S_WAKE ##1 seq_move)
      else $error("sleep transfer exceeded five cycles");
   AST_OSC_WAIT: assert property (@(posedge clk_i) disable iff (rst_i || abort)
      state == S_SYNC && clk_off |-> ##1 state == S_WAKE ##[1:WAKE_MAX] state == S_MOVE_A)
      else $error("oscillator start-up wait out of bound");
   AST_RESTART: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == S_MOVE_A && stopped |-> mclk_restart_o) and (!busy |-> !mclk_restart_o))
      else $error("clock restart request wrong");
   AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      busy |-> sys_irq_hold_o && cpu_halt_o)
      else $error("interrupt or processor released during transfer");
   AST_NMI: assert property (@(posedge clk_i) disable iff (rst_i)
      busy && nmi_i && state != S_WAIT |=> (state == S_IDLE) == $past(nmi_abort_enable))
      else $error("nmi abort behaviour wrong");
   AST_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_o == (global_irq_enable_i && (|(channel_done_flag & channel_irq_enable))))
      else $error("interrupt request does not match flags");
   AST_VEC_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      (masked == '0) == (irq_vector_word == 5'h00))
      else $error("vector not zero with nothing enabled");
   AST_VEC_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
      vec_access && masked[0] && !done_oh[0] |=> !channel_done_flag[0])
      else $error("vector access did not clear top flag");
   AST_NEXT_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
      vec_access && ((masked & ~top_oh) != '0) && global_irq_enable_i |=> irq_o)
      else $error("second pending flag lost its request");
   AST_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
      step && last |=> channel_done_flag[$past(cur)])
      else $error("done flag not set at count zero");
endmodule : dtil_dma_core

// ===== bench/dtil_trig_src.sv
`timescale 1ns/1ns
module dtil_trig_src
   import dtil_pkg::*;
#(
   parameter int N_CH = NCH_DEF
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Requests from the bench
   input wire logic [N_CH-1:0] fire_i,
   input wire logic rx_avail_i,
   input wire logic tx_need_i,
   // Trigger lines
   output logic [N_CH-1:0] trig_o
);
   logic [N_CH-1:0] req;
   logic [N_CH-1:0] hold_a;
   logic [N_CH-1:0] hold_b;
   // Serial unit: receive and transmit each own a trigger line
   assign req = fire_i | (N_CH'(rx_avail_i) << (N_CH - 2))
                | (N_CH'(tx_need_i) << (N_CH - 1));
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hold_a <= '0;
         hold_b <= '0;
      end
      else
      begin
         hold_a <= req;
         hold_b <= hold_a;
      end
   end
   // Two-cycle pulse, then low again so every request is a fresh edge
   assign trig_o = hold_a | hold_b;
endmodule : dtil_trig_src

// ===== bench/testbench.sv
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin err_total++; \
   $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
module testbench
   import dtil_pkg::*;
;
   logic clk_i, rst_i, cyc, stb, we, ack, global_irq_enable, nmi, halt, hold, restart, irq, rx, tx;
   logic [7:0] adr;
   logic [7:0] trig;
   logic [7:0] fire;
   logic [3:0] sel;
   logic [31:0] wdat, rdat;
   dtil_power_t power;
   dtil_xfer_t xfer;
   int err_total = 0;
   int n_tests = 0;
   dtil_sleep_t slp[8] = '{SLP_ACTIVE, SLP_ACTIVE, SLP_ZERO, SLP_ONE, SLP_THREE, SLP_THREE,
                           SLP_FOUR, SLP_FOUR};
   logic xtl[8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

   dtil_dma_core u_dtil_dma_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .trig_i(trig), .power_i(power), .global_irq_enable_i(global_irq_enable), .nmi_i(nmi),
      .xfer_o(xfer), .cpu_halt_o(halt), .sys_irq_hold_o(hold), .mclk_restart_o(restart),
      .irq_o(irq));
   dtil_trig_src u_dtil_trig_src (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
      .rx_avail_i(rx), .tx_need_i(tx), .trig_o(trig));

   initial
   begin
      clk_i = 0;
      forever #25 clk_i = ~clk_i;
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      `CHK("bus ack", 1'b1, ack)
      q = rdat;
      cyc <= 0;
      stb <= 0;
      we <= 0;
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      wb(1'b0, a, 32'h0, q);
   endtask : rd

   // One word on channel ch under power row ch; checks timing, flag and vector
   task automatic run_xfer(input int ch);
      int n, nrd, nwr, ndn, nbad, bound;
      logic rs, seen;
      logic [31:0] q;
      n = 0; nrd = 0; nwr = 0; ndn = 0; nbad = 0; seen = 0;
      rs = (slp[ch] == SLP_FOUR) || (slp[ch] == SLP_THREE && !xtl[ch]);
      bound = (slp[ch] == SLP_ACTIVE) ? 4 : (rs ? 5 + OSC_START_CYC : 5);
      wr(ADR_SIZE0 + 8'(4 * ch), 32'h1);
      wr(ADR_CHEN, 32'(1) << ch);
      @(posedge clk_i);
      power <= '{sleep: slp[ch], src_crystal: xtl[ch]};
      if (ch == 6)
         rx <= 1;
      else if (ch == 7)
         tx <= 1;
      else
         fire <= 8'(1 << ch);
      @(posedge clk_i);
      fire <= 0;
      rx <= 0;
      tx <= 0;
      while (xfer.busy !== 1'b1 && n < 10)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
      n = 0;
      while ((xfer.busy === 1'b1 || n == 0) && n < 300)
      begin
         n += int'(xfer.busy === 1'b1);
         nrd += int'(xfer.rd === 1'b1);
         nwr += int'(xfer.wr === 1'b1);
         ndn += int'(xfer.done === 1'b1);
         nbad += int'(halt !== 1'b1 || hold !== 1'b1);
         seen |= (restart === 1'b1);
         @(posedge clk_i);
         #1;
      end
      repeat (2)
      begin
         ndn += int'(xfer.done === 1'b1);
         @(posedge clk_i);
         #1;
      end
      `CHK("sync plus move cycles", 1'b1, n >= 4)
      `CHK("cycle time bound", 1'b1, n <= bound)
      `CHK("read strobes", 1, nrd)
      `CHK("write strobes", 1, nwr)
      `CHK("halt and hold gaps", 0, nbad)
      `CHK("clock restart", rs, seen)
      `CHK("done pulses", 1, ndn)
      `CHK("served channel", 3'(ch), xfer.chan)
      `CHK("irq with enables", 1'b1, irq)
      @(posedge clk_i);
      global_irq_enable <= 0;
      @(posedge clk_i);
      #1;
      `CHK("irq without global", 1'b0, irq)
      @(posedge clk_i);
      global_irq_enable <= 1;
      rd(ADR_VEC, q);
      `CHK("vector code", 32'(2 * ch + 2), q)
      rd(ADR_VEC, q);
      `CHK("vector after clear", 32'h0, q)
   endtask : run_xfer

   task automatic prio_vec();
      logic [31:0] q;
      int n;
      n = 0;
      wr(ADR_CTRL, 32'h0000_2400);
      wr(ADR_SIZE0, 32'h1);
      wr(ADR_SIZE0 + 8'h08, 32'h1);
      wr(ADR_SIZE0 + 8'h14, 32'h1);
      wr(ADR_CHEN, 32'h25);
      @(posedge clk_i);
      power <= '{sleep: SLP_ACTIVE, src_crystal: 1'b0};
      fire <= 8'h25;
      @(posedge clk_i);
      fire <= 0;
      do
      begin
         rd(ADR_STAT, q);
         n++;
      end
      while (q[7:0] !== 8'h25 && n < 30);
      `CHK("three flags", 8'h25, q[7:0])
      rd(ADR_VEC, q);
      `CHK("vector top enabled", 32'h6, q)
      #1;
      `CHK("irq still raised", 1'b1, irq)
      wr(ADR_VEC, 32'hFFFF_FFFF);
      rd(ADR_VEC, q);
      `CHK("vector after write", 32'h0, q)
      rd(ADR_VEC, q);
      `CHK("vector masked flag", 32'h0, q)
      #1;
      `CHK("irq masked flag", 1'b0, irq)
      rd(ADR_STAT, q);
      `CHK("masked flag kept", 8'h01, q[7:0])
      wr(ADR_STAT, 32'hFF);
   endtask : prio_vec

   task automatic nmi_case(input logic ab);
      logic [31:0] q;
      int n;
      n = 0;
      wr(ADR_CTRL, {31'h0, ab});
      wr(ADR_SIZE0 + 8'h0C, 32'h1);
      wr(ADR_CHEN, 32'h8);
      @(posedge clk_i);
      fire <= 8'h08;
      @(posedge clk_i);
      fire <= 0;
      while (xfer.busy !== 1'b1 && n < 10)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
      @(posedge clk_i);
      nmi <= 1;
      n = 0;
      #1;
      while (xfer.busy === 1'b1 && n < 20)
      begin
         n++;
         @(posedge clk_i);
         #1;
      end
      @(posedge clk_i);
      nmi <= 0;
      `CHK("busy after nmi", 1'b1, ab ? n <= 2 : n == 3)
      rd(ADR_STAT, q);
      `CHK("flag after nmi", !ab, q[3])
      wr(ADR_STAT, 32'hFF);
      wr(ADR_CHEN, 32'h0);
   endtask : nmi_case

   initial
   begin
      rst_i = 1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; wdat = 0;
      global_irq_enable = 0; nmi = 0; fire = 0; rx = 0; tx = 0;
      power = '{sleep: SLP_ACTIVE, src_crystal: 1'b0};
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      global_irq_enable <= 1;
      wr(ADR_CTRL, 32'h0000_FF00);
      for (int ch = 0; ch < 8; ch++)
         run_xfer(ch);
      prio_vec();
      nmi_case(1'b1);
      nmi_case(1'b0);
      final_report();
   end

   // Three deep-sleep wakes dominate; this leaves wide margin
   initial
   begin
      #(50 * 20000);
      err_total++;
      $display("mismatch watchdog expected 0 seen 1");
      final_report();
   end
endmodule : testbench
